// ===== verilog/slpc_top.sv
// sleep-mode and per-peripheral clock-gating controller
`timescale 1ns/10ps
module slpc_top #(
    parameter logic [slpc_pkg::WAIT_W-1:0] OSC_START_SHORT = 16'h0040,
    parameter logic [slpc_pkg::WAIT_W-1:0] OSC_START_LONG = 16'h4000
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sleep_instr,
    input wire logic sleep_permit,
    input wire logic [2:0] low_power_mode_code,
    input wire logic [slpc_pkg::GATE_W-1:0] peripheral_clock_gate_reg,
    input wire logic [3:0] clock_source_fuses,
    input wire logic adc_enabled,
    input wire logic timer2_async,
    input wire logic timer2_sync,
    input wire logic timer2_ovf_evt,
    input wire logic timer2_cmp_evt,
    input wire logic [1:0] timer2_irq_mask,
    input wire logic global_irq_en,
    input wire logic spm_ready_irq,
    input wire logic adc_done_irq,
    input wire logic other_irq,
    input wire logic ext_level_irq,
    input wire logic pin_change_irq,
    input wire logic twi_addr_match,
    input wire logic wdt_irq,
    input wire logic ext_rst_req,
    input wire logic wdt_rst_req,
    input wire logic bod_rst_req,
    output logic core_clk_en,
    output logic flash_clk_en,
    output logic io_clk_en,
    output logic adc_clk_en,
    output logic rtc_domain_clock_en,
    output logic osc_en,
    output logic timer_osc_en,
    output logic [slpc_pkg::GATE_W-1:0] periph_clk_en,
    output logic [slpc_pkg::GATE_W-1:0] io_access_block,
    output logic adc_conv_start,
    output logic irq_resume,
    output logic reset_vector_req,
    output logic sleeping
);
    import slpc_pkg::*;

    typedef struct packed {
        slpc_state_e st;
        logic [2:0] mode;
        logic rst_wake;
        logic [CK_W-1:0] ck;
        logic [GATE_W-1:0] periph;
        logic [GATE_W-1:0] block;
        logic [2:0] halt_cnt;
        logic wait_load;
        logic adc_start;
        logic irq_res;
        logic rst_vec;
        logic slp;
    } slpc_top_s;

    slpc_top_s r;
    slpc_top_s next_r;
    logic [6:0] pin_s;
    logic wait_done;
    logic [7:0] wake_src;
    logic [7:0] wake_hit;
    logic rst_hit;
    logic t2_wake;
    logic xtal;
    logic [2:0] eff_mode;
    logic [WAIT_W-1:0] start_cyc;

    // pins from outside the clock domain
    slpc_sync #(
        .W(7)
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .d({bod_rst_req, wdt_rst_req, ext_rst_req, wdt_irq, twi_addr_match, pin_change_irq, ext_level_irq}),
        .q(pin_s)
    );

    slpc_wait #(
        .W(WAIT_W)
    ) u_wait (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .load(r.wait_load),
        .load_val(start_cyc),
        .done(wait_done)
    );

    // crystal option decides standby and the start-up length
    assign xtal = clock_source_fuses[FUSE_XTAL_BIT];
    assign start_cyc = xtal ? OSC_START_LONG : OSC_START_SHORT;
    // standby without crystal falls back to power-down
    assign eff_mode = (low_power_mode_code == MODE_STBY && !xtal) ? MODE_PDOWN : low_power_mode_code;

    assign t2_wake = (timer2_ovf_evt & timer2_irq_mask[0] | timer2_cmp_evt & timer2_irq_mask[1])
                     & global_irq_en;

    always_comb begin
        wake_src = 8'h00;
        wake_src[WK_LEVEL] = pin_s[0];
        wake_src[WK_PINCHG] = pin_s[1];
        wake_src[WK_TWI] = pin_s[2];
        wake_src[WK_WDT] = pin_s[3];
        wake_src[WK_T2] = t2_wake;
        wake_src[WK_SPM] = spm_ready_irq;
        wake_src[WK_ADC] = adc_done_irq;
        wake_src[WK_OTHER] = other_irq;
    end

    assign wake_hit = wake_src & wake_mask(r.mode);
    assign rst_hit = |pin_s[6:4];

    // per-peripheral enables; gating only bites where the domain still runs
    function automatic logic [GATE_W-1:0] periph_en(input logic [CK_W-1:0] ck, input logic [GATE_W-1:0] g,
                                                   input logic t2a, input logic ps);
        logic [GATE_W-1:0] e;
        e = '0;
        e[GATE_TWI] = ck[CK_IO] & ~g[GATE_TWI];
        e[GATE_T0] = ck[CK_IO] & ~g[GATE_T0];
        e[GATE_T1] = ck[CK_IO] & ~g[GATE_T1];
        e[GATE_SPI] = ck[CK_IO] & ~g[GATE_SPI];
        e[GATE_USART] = ck[CK_IO] & ~g[GATE_USART];
        e[GATE_ADC] = ck[CK_ADC] & ~g[GATE_ADC];
        // sync timer 2 alone keeps the main clock in power-save
        e[GATE_T2] = t2a ? ck[CK_ASY] : ((ck[CK_IO] | (ps & ck[CK_OSC])) & ~g[GATE_T2]);
        periph_en = e;
    endfunction

    always_comb begin
        next_r = r;
        next_r.adc_start = 1'b0;
        next_r.irq_res = 1'b0;
        next_r.rst_vec = 1'b0;
        next_r.wait_load = 1'b0;
        case (r.st)
            ST_ACTIVE: begin
                next_r.ck = mode_clocks(1'b0, MODE_IDLE, timer2_async, timer2_sync);
                // no permit or a reserved code leaves the six main clocks running, the timer oscillator as timer2_async sets it
                if (sleep_instr && sleep_permit && mode_valid(low_power_mode_code)) begin
                    next_r.st = ST_SLEEP;
                    next_r.mode = eff_mode;
                    next_r.rst_wake = 1'b0;
                    next_r.slp = 1'b1;
                    // core is only stopped, never reset, so its storage holds
                    next_r.ck = mode_clocks(1'b1, eff_mode, timer2_async, timer2_sync);
                    next_r.adc_start = adc_enabled && (eff_mode == MODE_IDLE || eff_mode == MODE_ADCNR);
                end
            end
            ST_SLEEP: begin
                if (rst_hit || (|wake_hit)) begin
                    next_r.rst_wake = rst_hit;
                    if (!r.ck[CK_OSC]) begin
                        // oscillator first; derived domains wait for it
                        next_r.st = ST_OSC;
                        next_r.ck[CK_OSC] = 1'b1;
                        next_r.wait_load = 1'b1;
                    end else begin
                        next_r.st = ST_HALT;
                        next_r.halt_cnt = 3'h0;
                        next_r.ck = {timer2_async, 6'h3C};
                    end
                end
            end
            ST_OSC: begin
                next_r.rst_wake = r.rst_wake | rst_hit;
                if (wait_done) begin
                    next_r.st = ST_HALT;
                    next_r.halt_cnt = 3'h0;
                    next_r.ck = {timer2_async, 6'h3C};
                end
            end
            ST_HALT: begin
                next_r.rst_wake = r.rst_wake | rst_hit;
                next_r.halt_cnt = r.halt_cnt + 3'h1;
                if (r.halt_cnt == HALT_CYC - 3'h1) begin
                    next_r.st = ST_ACTIVE;
                    next_r.slp = 1'b0;
                    next_r.ck[CK_CORE] = 1'b1;
                    next_r.ck[CK_FLASH] = 1'b1;
                    next_r.rst_vec = r.rst_wake | rst_hit;
                    next_r.irq_res = ~(r.rst_wake | rst_hit);
                end
            end
            default: begin
                next_r.st = ST_ACTIVE;
            end
        endcase
        // enables follow the gate bits and domain clocks, async timer 2 ignoring its bit; module state is untouched
        next_r.periph = periph_en(next_r.ck, peripheral_clock_gate_reg, timer2_async,
                                  next_r.slp && next_r.mode == MODE_PSAVE);
        next_r.block = peripheral_clock_gate_reg & GATE_USED;
    end

    // enables change only on clock edges, so downstream gate cells see no runt pulse
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r.st <= ST_ACTIVE;
            r.mode <= MODE_IDLE;
            r.rst_wake <= 1'b0;
            r.ck <= 7'h3F;
            r.periph <= 8'hEF;
            r.block <= 8'h00;
            r.halt_cnt <= 3'h0;
            r.wait_load <= 1'b0;
            r.adc_start <= 1'b0;
            r.irq_res <= 1'b0;
            r.rst_vec <= 1'b0;
            r.slp <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign core_clk_en = r.ck[CK_CORE];
    assign flash_clk_en = r.ck[CK_FLASH];
    assign io_clk_en = r.ck[CK_IO];
    assign adc_clk_en = r.ck[CK_ADC];
    assign rtc_domain_clock_en = r.ck[CK_ASY];
    assign osc_en = r.ck[CK_OSC];
    assign timer_osc_en = r.ck[CK_TOSC];
    assign periph_clk_en = r.periph;
    assign io_access_block = r.block;
    assign adc_conv_start = r.adc_start;
    assign irq_resume = r.irq_res;
    assign reset_vector_req = r.rst_vec;
    assign sleeping = r.slp;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // standby wake window, kept local so the delay range sees a plain constant
    localparam int STBY_BOUND = STBY_WAKE_CYC;

    AST_NOP_NO_PERMIT: assert property (
        (r.st == ST_ACTIVE && sleep_instr && !sleep_permit) |=> (r.st == ST_ACTIVE && core_clk_en && io_clk_en))
        else $error("sleep entered without permit");

    AST_RESERVED_CODE: assert property (
        (r.st == ST_ACTIVE && sleep_instr && !mode_valid(low_power_mode_code)) |=> !sleeping)
        else $error("reserved mode code entered sleep");

    AST_HALT_FOUR: assert property (
        (r.st == ST_HALT && $past(r.st) != ST_HALT) |-> (r.st == ST_HALT && !core_clk_en)[*4]
        ##1 (core_clk_en && (irq_resume || reset_vector_req)))
        else $error("halt not four cycles");

    AST_IDLE_CLOCKS: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_IDLE) |-> (!core_clk_en && !flash_clk_en && io_clk_en
        && adc_clk_en && rtc_domain_clock_en))
        else $error("idle clock set wrong");

    AST_ADCNR_CLOCKS: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_ADCNR) |-> (!io_clk_en && !core_clk_en && adc_clk_en && osc_en))
        else $error("noise reduction clock set wrong");

    AST_PDOWN_CLOCKS: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_PDOWN) |-> (!osc_en && !io_clk_en && !adc_clk_en && periph_clk_en == 8'h00))
        else $error("power-down left a clock running");

    AST_ADC_START: assert property (
        (r.st == ST_ACTIVE && sleep_instr && sleep_permit && adc_enabled && low_power_mode_code == MODE_IDLE)
        |=> adc_conv_start ##1 !adc_conv_start)
        else $error("no conversion start on idle entry");

    AST_STBY_SIX: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_STBY && |wake_hit) |-> osc_en ##[1:STBY_BOUND] core_clk_en)
        else $error("standby wake too slow");

    AST_OSC_FIRST: assert property (
        $rose(io_clk_en) |-> osc_en && $past(osc_en))
        else $error("derived clock before oscillator");

    AST_PDOWN_NO_T2: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_PDOWN && !rst_hit && wake_src[3:0] == 4'h0) |=> r.st == ST_SLEEP)
        else $error("power-down woke on a foreign source");

    AST_GATE_BLOCK: assert property (
        (r.st == ST_ACTIVE && $past(r.st) == ST_ACTIVE) |-> (io_access_block == ($past(peripheral_clock_gate_reg)
        & GATE_USED) && (periph_clk_en & io_access_block & ~8'h40) == 8'h00))
        else $error("gated module still clocked or open");

    AST_PSAVE_CLOCKS: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_PSAVE) |-> (!core_clk_en && !flash_clk_en && !io_clk_en
        && !adc_clk_en))
        else $error("power-save left a core clock running");

    AST_TOSC_SAVE: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_PSAVE) |-> (timer_osc_en == rtc_domain_clock_en))
        else $error("timer oscillator and async domain disagree");

    AST_STBY_CLOCKS: assert property (
        (r.st == ST_SLEEP && r.mode == MODE_STBY) |-> (osc_en && !io_clk_en && !adc_clk_en && !core_clk_en))
        else $error("standby clock set wrong");

    // converter and timer 2 may legitimately keep a clock in the deeper modes
    AST_SLEEP_GATES: assert property (
        (r.st == ST_SLEEP && r.mode != MODE_IDLE) |-> ((periph_clk_en & 8'hBE) == 8'h00))
        else $error("module clock running in deep sleep");

    AST_RESUME_CORE: assert property (
        (irq_resume || reset_vector_req) |-> (core_clk_en && flash_clk_en && !sleeping
        && $past(r.st) == ST_HALT))
        else $error("core handed back without clocks");

    AST_RST_WINS: assert property (
        (r.st != ST_ACTIVE && rst_hit) |=> !irq_resume)
        else $error("reset during sleep resumed after sleep instruction");

    COV_IDLE_WAKE: cover property (r.st == ST_SLEEP && r.mode == MODE_IDLE ##1 r.st == ST_HALT);
    COV_PDOWN_OSC: cover property (r.st == ST_OSC ##1 r.st == ST_HALT);
    COV_RST_WAKE: cover property (reset_vector_req);
    COV_STBY: cover property (r.st == ST_SLEEP && r.mode == MODE_STBY ##1 r.st == ST_HALT);
    COV_PSAVE_WAKE: cover property (r.st == ST_SLEEP && r.mode == MODE_PSAVE ##1 r.st != ST_SLEEP);
endmodule // slpc_top

// ===== verilog/slpc_pkg.sv
// constants, types and decode functions of the sleep-mode power controller
package slpc_pkg;

    // low-power mode codes
    localparam logic [2:0] MODE_IDLE = 3'h0;
    localparam logic [2:0] MODE_ADCNR = 3'h1;
    localparam logic [2:0] MODE_PDOWN = 3'h2;
    localparam logic [2:0] MODE_PSAVE = 3'h3;
    localparam logic [2:0] MODE_STBY = 3'h6;

    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_SLEEP = 2'b01,
        ST_OSC = 2'b10,
        ST_HALT = 2'b11
    } slpc_state_e;

    // clock-gate register bit positions
    localparam int GATE_W = 8;
    localparam int GATE_TWI = 7;
    localparam int GATE_T2 = 6;
    localparam int GATE_T0 = 5;
    localparam int GATE_RSV = 4;
    localparam int GATE_T1 = 3;
    localparam int GATE_SPI = 2;
    localparam int GATE_USART = 1;
    localparam int GATE_ADC = 0;
    localparam logic [7:0] GATE_USED = 8'hEF;

    // wake source bit positions
    localparam int WK_LEVEL = 0;
    localparam int WK_PINCHG = 1;
    localparam int WK_TWI = 2;
    localparam int WK_WDT = 3;
    localparam int WK_T2 = 4;
    localparam int WK_SPM = 5;
    localparam int WK_ADC = 6;
    localparam int WK_OTHER = 7;
    localparam logic [7:0] WAKE_IDLE = 8'hFF;
    localparam logic [7:0] WAKE_ADCNR = 8'h7F;
    localparam logic [7:0] WAKE_PDOWN = 8'h0F;
    localparam logic [7:0] WAKE_PSAVE = 8'h1F;
    localparam logic [7:0] WAKE_STBY = 8'h0F;

    // clock vector positions
    localparam int CK_W = 7;
    localparam int CK_CORE = 0;
    localparam int CK_FLASH = 1;
    localparam int CK_IO = 2;
    localparam int CK_ADC = 3;
    localparam int CK_ASY = 4;
    localparam int CK_OSC = 5;
    localparam int CK_TOSC = 6;

    localparam logic [2:0] HALT_CYC = 3'h4;
    localparam int STBY_WAKE_CYC = 6;
    localparam int FUSE_XTAL_BIT = 3;
    localparam int WAIT_W = 16;

    function automatic logic mode_valid(input logic [2:0] m);
        mode_valid = (m == MODE_IDLE) || (m == MODE_ADCNR) || (m == MODE_PDOWN) ||
                     (m == MODE_PSAVE) || (m == MODE_STBY);
    endfunction

    function automatic logic [7:0] wake_mask(input logic [2:0] m);
        case (m)
            MODE_IDLE: wake_mask = WAKE_IDLE;
            MODE_ADCNR: wake_mask = WAKE_ADCNR;
            MODE_PDOWN: wake_mask = WAKE_PDOWN;
            MODE_PSAVE: wake_mask = WAKE_PSAVE;
            MODE_STBY: wake_mask = WAKE_STBY;
            default: wake_mask = 8'h00;
        endcase
    endfunction

    // {tosc, osc, asy, adc, io, flash, core}
    function automatic logic [6:0] mode_clocks(input logic slp, input logic [2:0] m,
                                               input logic t2a, input logic t2s);
        if (!slp) begin
            mode_clocks = {t2a, 6'h3F};
        end else begin
            case (m)
                MODE_IDLE: mode_clocks = {t2a, 6'h3C};
                MODE_ADCNR: mode_clocks = {t2a, 6'h38};
                MODE_PDOWN: mode_clocks = 7'h00;
                MODE_PSAVE: mode_clocks = {t2a, t2s, t2a, 4'h0};
                MODE_STBY: mode_clocks = 7'h20;
                default: mode_clocks = {t2a, 6'h3F};
            endcase
        end
    endfunction

endpackage

// ===== verilog/slpc_sync.sv
// two-flop synchroniser for pin-level wake and reset sources
`timescale 1ns/10ps
module slpc_sync #(
    parameter int W = 7
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } slpc_sync_s;

    slpc_sync_s r;
    slpc_sync_s next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule // slpc_sync

// ===== verilog/slpc_wait.sv
// oscillator start-up wait counter, one-cycle done pulse
`timescale 1ns/10ps
module slpc_wait #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic done
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic busy;
        logic done;
    } slpc_wait_s;

    slpc_wait_s r;
    slpc_wait_s next_r;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        if (load) begin
            next_r.cnt = load_val;
            next_r.busy = 1'b1;
        end else if (r.busy) begin
            if (r.cnt <= W'(1)) begin
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
            end else begin
                next_r.cnt = r.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign done = r.done;
endmodule // slpc_wait

// ===== verilog/README_unused.sv
// intentionally empty
`timescale 1ns/10ps

// ===== test/slpc_core_model.sv
// partner model of the core and interrupt sources
`timescale 1ns/10ps
module slpc_core_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sleep_req,
    input wire logic [8:0] arm,
    input wire logic clear,
    input wire logic resume,
    output logic sleep_instr,
    output logic [8:0] src
);
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sleep_instr <= 1'b0;
            src <= 9'h000;
        end else begin
            sleep_instr <= sleep_req;
            // levels held until the core is back or clear is raised
            src <= (src | arm) & ~{9{resume | clear}};
        end
    end
endmodule // slpc_core_model

// ===== test/tb.sv
// self-checking bench of the sleep-mode power controller
`timescale 1ns/10ps
module tb;
    import slpc_pkg::*;
    logic mclk, sys_rst, sleep_req, sleep_instr, sleep_permit, adc_enabled, global_irq_en, clear;
    logic irq_resume, reset_vector_req, sleeping, adc_conv_start, rv;
    logic [2:0] m;
    logic [7:0] gate, pce, blk;
    logic [6:0] ck;
    logic [3:0] fuses;
    logic [1:0] t2m;
    logic [8:0] arm, src;
    logic [7:0] wm;
    logic t2a, t2s, t2c, wdt_rst, bod_rst;
    int miscompares, checks, convs, n, k, ec;

    slpc_core_model i_slpc_core_model (.mclk(mclk), .sys_rst(sys_rst), .sleep_req(sleep_req), .arm(arm),
        .clear(clear), .resume(irq_resume | reset_vector_req), .sleep_instr(sleep_instr), .src(src));
    slpc_top #(.OSC_START_SHORT(16'h0004), .OSC_START_LONG(16'h0008)) i_slpc_top (.mclk(mclk),
        .sys_rst(sys_rst), .sleep_instr(sleep_instr), .sleep_permit(sleep_permit),
        .low_power_mode_code(m), .peripheral_clock_gate_reg(gate), .clock_source_fuses(fuses),
        .adc_enabled(adc_enabled), .timer2_async(t2a), .timer2_sync(t2s), .timer2_ovf_evt(src[4]),
        .timer2_cmp_evt(t2c), .timer2_irq_mask(t2m), .global_irq_en(global_irq_en),
        .spm_ready_irq(src[5]), .adc_done_irq(src[6]), .other_irq(src[7]), .ext_level_irq(src[0]),
        .pin_change_irq(src[1]), .twi_addr_match(src[2]), .wdt_irq(src[3]), .ext_rst_req(src[8]),
        .wdt_rst_req(wdt_rst), .bod_rst_req(bod_rst), .core_clk_en(ck[CK_CORE]), .flash_clk_en(ck[CK_FLASH]),
        .io_clk_en(ck[CK_IO]), .adc_clk_en(ck[CK_ADC]), .rtc_domain_clock_en(ck[CK_ASY]),
        .osc_en(ck[CK_OSC]), .timer_osc_en(ck[CK_TOSC]), .periph_clk_en(pce), .io_access_block(blk),
        .adc_conv_start(adc_conv_start), .irq_resume(irq_resume), .reset_vector_req(reset_vector_req),
        .sleeping(sleeping));

    // {tosc, osc, asy, adc, io, flash, core}; timer 2 runs on neither clock here
    function automatic logic [6:0] exp_ck(input logic [2:0] c);
        case (c)
            3'h0: exp_ck = 7'h3C;
            3'h1: exp_ck = 7'h38;
            3'h2, 3'h3: exp_ck = 7'h00;
            3'h6: exp_ck = 7'h20;
            default: exp_ck = 7'h3F;
        endcase
    endfunction

    function automatic logic [7:0] exp_wake(input logic [2:0] c);
        case (c)
            3'h0: exp_wake = 8'hFF;
            3'h1: exp_wake = 8'h7F;
            3'h3: exp_wake = 8'h1F;
            default: exp_wake = 8'h0F;
        endcase
    endfunction

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask

    task automatic enter(input logic [2:0] c);
        m = c;
        sleep_req = 1'b1;
        tick(1);
        sleep_req = 1'b0;
        tick(2);
    endtask

    // bounded wait for the core to be handed back
    task automatic wake(input logic [8:0] s);
        arm = s;
        n = 0;
        tick(1);
        arm = 9'h000;
        n = 1;
        while (!(irq_resume | reset_vector_req) && n < 200) begin
            tick(1);
            n++;
        end
        rv = reset_vector_req;
        chk("wake seen", 8'h01, {7'h00, n < 200});
    endtask

    task automatic summarize;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk) if (adc_conv_start === 1'b1) convs++;

    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        summarize();
    end

    initial begin
        {sleep_req, clear, sleep_permit, adc_enabled, global_irq_en} = 5'h00;
        {m, gate, fuses, t2m, arm} = '0;
        {t2a, t2s, t2c, wdt_rst, bod_rst} = 5'h00;
        sys_rst = 1'b1;
        k = $urandom(32'hCB4359E7);
        tick(2);
        chk("reset gates", 8'hEF, pce);
        sys_rst = 1'b0;
        fuses = 4'h8;
        t2m = 2'h1;
        adc_enabled = 1'b1;
        enter(3'h2);
        chk("permit low", 8'h3F, {sleeping, ck[5:0]});
        sleep_permit = 1'b1;
        for (int c = 0; c < 8; c++) begin
            gate = 8'($urandom);
            // converter switched off together with the gating of its clock
            adc_enabled = !gate[GATE_ADC];
            if (c < 2 && adc_enabled)
                ec++;
            tick(3);
            chk("gates", ~gate & 8'hEF, pce);
            chk("blocks", gate & 8'hEF, blk);
            enter(3'(c));
            chk("clocks", {1'b0, exp_ck(3'(c))}, {1'b0, ck});
            if (c != 0 && c != 1)
                chk("gates asleep", (c == 4 || c == 5 || c == 7) ? ~gate & 8'hEF : 8'h00, pce);
            if (exp_wake(3'(c)) != 8'hFF && !(c == 4 || c == 5 || c == 7)) begin
                global_irq_en = 1'b0;
                arm = {1'b0, ~exp_wake(3'(c)) | ((c == 3) ? 8'h10 : 8'h00)};
                tick(12);
                arm = 9'h000;
                chk("masked source", 8'h01, {7'h00, sleeping});
                clear = 1'b1;
                tick(1);
                clear = 1'b0;
                tick(3);
            end
            global_irq_en = 1'b1;
            if (c == 0) begin
                wake(9'h080);
                chk("idle wake cycles", 8'h02 + {5'h00, HALT_CYC}, 8'(n));
            end else if (!(c == 4 || c == 5 || c == 7)) begin
                wm = exp_wake(3'(c));
                do k = $urandom % 8; while (!wm[k]);
                wake(9'(1 << k));
                if (c == 6)
                    chk("standby fast", 8'h01, {7'h00, n <= 9});
            end
            if (!(c == 4 || c == 5 || c == 7)) begin
                chk("resume kind", 8'h00, {7'h00, rv});
                chk("clocks back", 8'h3F, {2'h0, ck[5:0]});
            end
        end
        chk("conversions", 8'(ec), 8'(convs));
        enter(3'h2);
        wake(9'h100);
        chk("reset vector", 8'h01, {7'h00, rv});
        // timer 2 on its own oscillator, then on the main clock, in power-save
        gate = 8'h00;
        for (int j = 0; j < 2; j++) begin
            {t2a, t2s} = j ? 2'b01 : 2'b10;
            t2m = 2'h1;
            tick(3);
            chk("timer osc", {7'h00, t2a}, {7'h00, ck[CK_TOSC]});
            enter(MODE_PSAVE);
            chk("save clocks", t2a ? 8'h50 : 8'h20, {1'b0, ck});
            chk("save gates", 8'h40, pce);
            // compare event with only the overflow enable set must not wake
            t2c = 1'b1;
            tick(6);
            chk("t2 mask", 8'h01, {7'h00, sleeping});
            t2m = 2'h2;
            wake(9'h000);
            t2c = 1'b0;
            chk("t2 resume", 8'h00, {7'h00, rv});
        end
        {t2a, t2s} = 2'b00;
        // watchdog and brown-out resets wake to the reset vector
        for (int j = 0; j < 2; j++) begin
            enter(3'(j));
            {wdt_rst, bod_rst} = j ? 2'b10 : 2'b01;
            wake(9'h000);
            {wdt_rst, bod_rst} = 2'b00;
            chk("reset source", 8'h01, {7'h00, rv});
        end
        tick(4);
        summarize();
    end
endmodule // tb
